// file: hdl/wdt_pkg.sv
// Summary of operation
// RQ1: watchdog comes up off until unlocked enable
// RQ2: count advances on millisecond reference ticks only
// RQ3: expiry after 2.048 s causes reset
// RQ4: 1.792 s low-water point raises non-maskable warning
// RQ5: any kick write restarts the count
// RQ6: debug hold freezes count while cpu halted
// RQ7: stopped reference clock simply freezes count
// RQ8: software writes on-code then sets on bit
// RQ9: software writes off-code then sets off bit
// RQ10: on/off bits ignored without matching code
// RQ11: register writes need privileged system mode
// RQ12: config bit 1 turns off, bit 0 on
// RQ13: config resets with only off bit set
// RQ14: unlock code lives in low 16 bits
// RQ15: registers kept by always-on reset only
// RQ16: expiry sets reset-cause watchdog flag, bit 3
// RQ17: debug hold option is bit 10
// RQ18: warn at 1792 ticks, expire at 2048
// RQ19: enabling zeroes count, consumed code cleared
package wdt_pkg;

  // ***************************************************
  // register map
  // ***************************************************
  localparam logic [31:0] CONFIG_ADDR    = 32'h4000_6000;
  localparam logic [31:0] UNLOCK_ADDR    = 32'h4000_6004;
  localparam logic [31:0] KICK_ADDR      = 32'h4000_6008;
  localparam logic [31:0] DBG_CFG_ADDR   = 32'h4000_600c;
  localparam logic [31:0] IRQ_STAT_ADDR  = 32'h4000_6030;
  localparam logic [31:0] IRQ_MASK_ADDR  = 32'h4000_6034;
  localparam logic [31:0] CAUSE_ADDR     = 32'h4000_6038;

  // ***************************************************
  // fields and reset values
  // ***************************************************
  localparam int          CFG_ON_BIT     = 0;
  localparam int          CFG_OFF_BIT    = 1;
  localparam logic [31:0] CFG_RESET      = 32'h0000_0002;
  localparam logic [15:0] UNLOCK_ON_CODE = 16'heabe;
  localparam logic [15:0] UNLOCK_OFF_CODE = 16'hdead;
  localparam logic [15:0] UNLOCK_RESET   = 16'h0000;
  localparam int          DBG_HOLD_BIT   = 10;
  localparam logic [31:0] DBG_CFG_RESET  = 32'h0000_0400;
  localparam int          CAUSE_WDT_BIT  = 3;
  localparam int          EV_WARN_BIT    = 0;
  localparam int          EV_EXPIRE_BIT  = 1;
  localparam logic [1:0]  EV_RESET       = 2'h0;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

  // ***************************************************
  // timing, in reference ticks
  // ***************************************************
  localparam int REF_PERIOD_US  = 1000;      // 1 kHz reference
  localparam int WARN_TIME_US   = 1792000;   // 1.792 s
  localparam int EXPIRE_TIME_US = 2048000;   // 2.048 s
  localparam int WARN_TICKS     = WARN_TIME_US / REF_PERIOD_US;
  localparam int EXPIRE_TICKS   = EXPIRE_TIME_US / REF_PERIOD_US;
  localparam int CNT_W          = 12;

  // ***************************************************
  // types
  // ***************************************************
  typedef enum logic [2:0] {
    SEL_NONE, SEL_CONFIG, SEL_UNLOCK, SEL_KICK,
    SEL_DBG, SEL_STAT, SEL_MASK, SEL_CAUSE
  } reg_sel_e;

  typedef struct packed {
    logic        meta;    // first synchroniser stage
    logic        stable;  // second stage
    logic        last;    // previous stable value
  } sync_state_s;

  typedef struct packed {
    logic [CNT_W-1:0] count;  // ticks since restart
  } cnt_state_s;

  typedef struct packed {
    logic        enabled;   // watchdog running
    logic [15:0] unlock;    // armed unlock code
    logic        dbg_hold;  // hold count in debug halt
    logic [1:0]  status;    // sticky events
    logic [1:0]  mask;      // interrupt mask
    logic        cause;     // reset-cause watchdog flag
    logic        ap_valid;  // data phase pending
    logic        ap_write;  // pending is a write
    logic        ap_priv;   // pending was privileged
    reg_sel_e    ap_sel;    // pending register
    logic [31:0] rdata;     // read data
    logic        reset_req; // reset request pulse
  } wdt_state_s;

endpackage

// file: hdl/ref_tick_sync.sv
`timescale 1ns/100ps
`default_nettype none
module ref_tick_sync
  import wdt_pkg::*;
(
  input  wire logic hclk,     // system clock
  input  wire logic hresetn,  // async reset, active low
  input  wire logic ref_in,   // asynchronous reference pin
  output logic      tick      // one-cycle pulse per rising edge
);

  sync_state_s st;       // registered state
  sync_state_s next_st;  // next state

  // only the second stage and its delayed copy feed the detector
  always_comb begin
    next_st        = st;
    next_st.meta   = ref_in;
    next_st.stable = st.meta;
    next_st.last   = st.stable;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // a stopped reference simply yields no ticks
  assign tick = st.stable & ~st.last;  // see RQ7

endmodule
`default_nettype wire

// file: hdl/wdt_counter.sv
`timescale 1ns/100ps
`default_nettype none
module wdt_counter
  import wdt_pkg::*;
#(
  parameter int WARN   = WARN_TICKS,   // low-water point
  parameter int EXPIRE = EXPIRE_TICKS  // expiry point
) (
  input  wire logic             hclk,     // system clock
  input  wire logic             hresetn,  // async reset, active low
  input  wire logic             advance,  // count one tick
  input  wire logic             restart,  // back to zero
  output logic [CNT_W-1:0]      count,    // current count
  output logic                  warn,     // pulse at low-water point
  output logic                  expire    // pulse at expiry
);

  cnt_state_s st;       // registered state
  cnt_state_s next_st;  // next state

  localparam logic [CNT_W-1:0] WARN_LAST   = CNT_W'(WARN - 1);
  localparam logic [CNT_W-1:0] EXPIRE_LAST = CNT_W'(EXPIRE - 1);

  // restart wins over a tick in the same cycle
  assign warn   = advance & ~restart & (st.count == WARN_LAST);  // see RQ18
  assign expire = advance & ~restart & (st.count == EXPIRE_LAST);  // see RQ18

  always_comb begin
    next_st = st;
    if (restart || expire) begin
      next_st.count = '0;
    end else if (advance) begin
      next_st.count = st.count + CNT_W'(1);  // see RQ2
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count = st.count;

endmodule
`default_nettype wire

// file: hdl/protected_watchdog_timer.sv
`timescale 1ns/100ps
`default_nettype none
module protected_watchdog_timer
  import wdt_pkg::*;
#(
  parameter int WARN   = WARN_TICKS,   // early warning, in ticks
  parameter int EXPIRE = EXPIRE_TICKS  // expiry, in ticks
) (
  input  wire logic        hclk,         // system clock, 100 mhz
  input  wire logic        hresetn,      // always-on reset, low
  input  wire logic        hsel,         // slave select
  input  wire logic [31:0] haddr,        // byte address
  input  wire logic [1:0]  htrans,       // transfer type
  input  wire logic        hwrite,       // write when high
  input  wire logic [2:0]  hsize,        // transfer size
  input  wire logic [3:0]  hprot,        // protection, bit 1 priv
  input  wire logic [31:0] hwdata,       // write data
  input  wire logic        hready,       // bus ready in
  output logic             hreadyout,    // slave ready
  output logic             hresp,        // response, always okay
  output logic [31:0]      hrdata,       // read data
  input  wire logic        millisecond_ref_clock, // 1 khz reference
  input  wire logic        cpu_debug_halted, // cpu halted by debugger
  output logic             wdt_reset_req,  // one-cycle reset pulse
  output logic             early_warn_nmi, // non-maskable warning
  output logic             irq,            // masked event interrupt
  output logic             reset_cause_wdt_flag, // expiry recorded
  output logic             wdt_active      // watchdog running
);

  // ***************************************************
  // state and submodules
  // ***************************************************
  wdt_state_s       st;        // registered state
  wdt_state_s       next_st;   // next state
  logic             ref_tick;  // synchronised reference edge
  logic             advance;   // counter may step
  logic             restart;   // counter back to zero
  logic [CNT_W-1:0] count;     // current count
  logic             warn;      // low-water event
  logic             expire;    // expiry event
  logic             wr_commit; // accepted write in data phase
  logic             turn_on;   // unlocked enable
  logic             turn_off;  // unlocked disable
  logic             kick;      // restart register written
  logic             ap_take;   // address phase taken
  reg_sel_e         sel;       // decoded address
  logic [1:0]       ev_set;    // events this cycle
  logic [1:0]       ev_clr;    // write-one-to-clear bits

  // the reference pin is asynchronous, so it is synchronised first
  ref_tick_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ref_in  (millisecond_ref_clock),
    .tick    (ref_tick)
  );

  wdt_counter #(
    .WARN   (WARN),
    .EXPIRE (EXPIRE)
  ) u_cnt (
    .hclk    (hclk),
    .hresetn (hresetn),
    .advance (advance),
    .restart (restart),
    .count   (count),
    .warn    (warn),
    .expire  (expire)
  );

  // ***************************************************
  // counting control
  // ***************************************************
  // ticks only count while running and not held by the debugger
  assign advance = ref_tick & st.enabled             // see RQ2
                 & ~(st.dbg_hold & cpu_debug_halted);  // see RQ6
  // enabling and kicking both start the interval over
  assign restart = kick | turn_on;  // see RQ5

  // ***************************************************
  // bus decode
  // ***************************************************
  assign ap_take   = hsel & hready & htrans[1];
  assign wr_commit = st.ap_valid & st.ap_write & st.ap_priv;  // see RQ11
  assign kick      = wr_commit & (st.ap_sel == SEL_KICK);     // see RQ5
  // each bit acts only with its own code already armed
  assign turn_on   = wr_commit & (st.ap_sel == SEL_CONFIG)
                   & hwdata[CFG_ON_BIT]                        // see RQ12
                   & (st.unlock == UNLOCK_ON_CODE);            // see RQ10
  assign turn_off  = wr_commit & (st.ap_sel == SEL_CONFIG)
                   & hwdata[CFG_OFF_BIT]                       // see RQ12
                   & (st.unlock == UNLOCK_OFF_CODE);           // see RQ10

  // address to register; anything else reads zero
  always_comb begin
    unique case (haddr)
      CONFIG_ADDR:   sel = SEL_CONFIG;
      UNLOCK_ADDR:   sel = SEL_UNLOCK;
      KICK_ADDR:     sel = SEL_KICK;
      DBG_CFG_ADDR:  sel = SEL_DBG;
      IRQ_STAT_ADDR: sel = SEL_STAT;
      IRQ_MASK_ADDR: sel = SEL_MASK;
      CAUSE_ADDR:    sel = SEL_CAUSE;
      default:       sel = SEL_NONE;
    endcase
  end

  // sticky events; a set in the clearing cycle wins
  always_comb begin
    ev_set                = '0;
    ev_set[EV_WARN_BIT]   = warn;
    ev_set[EV_EXPIRE_BIT] = expire;
    ev_clr = (wr_commit && st.ap_sel == SEL_STAT) ? hwdata[1:0] : 2'h0;
  end

  // ***************************************************
  // next state
  // ***************************************************
  always_comb begin
    next_st           = st;
    next_st.reset_req = expire;  // see RQ3
    next_st.status    = (st.status & ~ev_clr) | ev_set;  // see RQ4
    // record the cause; set wins over a software clear
    if (expire) begin
      next_st.cause = 1'b1;  // see RQ16
    end else if (wr_commit && st.ap_sel == SEL_CAUSE
                 && hwdata[CAUSE_WDT_BIT]) begin
      next_st.cause = 1'b0;
    end
    // data phase writes; unprivileged ones leave no trace
    if (wr_commit) begin
      unique case (st.ap_sel)
        SEL_UNLOCK: begin
          next_st.unlock = hwdata[15:0];  // see RQ14
        end
        SEL_DBG: begin
          next_st.dbg_hold = hwdata[DBG_HOLD_BIT];  // see RQ17
        end
        SEL_MASK: begin
          next_st.mask = hwdata[1:0];
        end
        default: begin
          // config, kick, status and cause act through terms above
        end
      endcase
    end
    // a successful turn on or off consumes the armed code
    if (turn_on) begin
      next_st.enabled = 1'b1;           // see RQ8
      next_st.unlock  = UNLOCK_RESET;   // see RQ19
    end else if (turn_off) begin
      next_st.enabled = 1'b0;           // see RQ9
      next_st.unlock  = UNLOCK_RESET;   // see RQ19
    end
    // address phase capture; read data is ready for the data phase
    next_st.ap_valid = ap_take;
    next_st.ap_write = hwrite;
    next_st.ap_priv  = hprot[1];
    next_st.ap_sel   = ap_take ? sel : SEL_NONE;
    next_st.rdata    = '0;
    if (ap_take && !hwrite) begin
      unique case (sel)
        SEL_CONFIG: begin
          next_st.rdata[CFG_ON_BIT]  = st.enabled;
          next_st.rdata[CFG_OFF_BIT] = ~st.enabled;  // see RQ13
        end
        SEL_UNLOCK: begin
          next_st.rdata[15:0] = st.unlock;
        end
        SEL_DBG: begin
          next_st.rdata[DBG_HOLD_BIT] = st.dbg_hold;
        end
        SEL_STAT: begin
          next_st.rdata[1:0] = st.status;
        end
        SEL_MASK: begin
          next_st.rdata[1:0] = st.mask;
        end
        SEL_CAUSE: begin
          next_st.rdata[CAUSE_WDT_BIT] = st.cause;
        end
        default: begin
          // kick and unmapped addresses read zero
        end
      endcase
    end
  end

  // ***************************************************
  // registers
  // ***************************************************
  // only the always-on reset touches these, so core resets and
  // deep sleep leave the watchdog setup intact
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st          <= '0;                       // see RQ15
      st.enabled  <= CFG_RESET[CFG_ON_BIT];    // see RQ1
      st.unlock   <= UNLOCK_RESET;
      st.dbg_hold <= DBG_CFG_RESET[DBG_HOLD_BIT];
      st.status   <= EV_RESET;
      st.mask     <= EV_RESET;
      st.ap_sel   <= SEL_NONE;
    end else begin
      st <= next_st;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  // zero wait states keeps the slave simple
  assign hreadyout            = 1'b1;
  assign hresp                = 1'b0;
  assign hrdata               = st.rdata;
  assign wdt_reset_req        = st.reset_req;
  assign early_warn_nmi       = st.status[EV_WARN_BIT];  // see RQ4
  assign irq                  = |(st.status & st.mask);
  assign reset_cause_wdt_flag = st.cause;
  assign wdt_active           = st.enabled;

  // ***************************************************
  // checks
  // ***************************************************
  off_after_reset_a: assert property (  // see RQ1
    @(posedge hclk) $rose(hresetn) |-> !st.enabled)
    else $error("watchdog running after reset");

  count_source_a: assert property (  // see RQ2
    @(posedge hclk) disable iff (!hresetn)
    (count != $past(count)) |-> $past(ref_tick || restart))
    else $error("count moved without a reference tick");

  expiry_reset_a: assert property (  // see RQ3
    @(posedge hclk) disable iff (!hresetn)
    expire |=> wdt_reset_req && reset_cause_wdt_flag && count == 0)
    else $error("expiry without reset and cause");

  expiry_point_a: assert property (  // see RQ18
    @(posedge hclk) disable iff (!hresetn)
    expire |-> count == CNT_W'(EXPIRE - 1) && st.enabled)
    else $error("expiry at wrong count");

  warn_nmi_a: assert property (  // see RQ4
    @(posedge hclk) disable iff (!hresetn)
    warn |=> early_warn_nmi && count == CNT_W'(WARN))
    else $error("warning not raised at low-water point");

  kick_restart_a: assert property (  // see RQ5
    @(posedge hclk) disable iff (!hresetn)
    kick |=> count == 0)
    else $error("kick did not restart count");

  debug_hold_a: assert property (  // see RQ6
    @(posedge hclk) disable iff (!hresetn)
    st.dbg_hold && cpu_debug_halted && !restart |=> $stable(count))
    else $error("count moved during debug halt");

  locked_enable_a: assert property (  // see RQ10
    @(posedge hclk) disable iff (!hresetn)
    !st.enabled && st.unlock != UNLOCK_ON_CODE |=> !st.enabled)
    else $error("enable accepted without code");

  unpriv_write_a: assert property (  // see RQ11
    @(posedge hclk) disable iff (!hresetn)
    st.ap_valid && st.ap_write && !st.ap_priv && !turn_on && !turn_off
    |=> $stable(st.unlock) && $stable(st.mask))
    else $error("unprivileged write took effect");

  enable_zero_a: assert property (  // see RQ19
    @(posedge hclk) disable iff (!hresetn)
    turn_on |=> st.enabled && count == 0 && st.unlock == UNLOCK_RESET)
    else $error("enable left count or code behind");

  // checks use the parameters, not the nominal counts, so a bench
  // may shorten the intervals and still be judged by the same rules
  off_locked_a: assert property (  // see RQ10
    @(posedge hclk) disable iff (!hresetn)
    st.enabled && st.unlock != UNLOCK_OFF_CODE |=> st.enabled)
    else $error("disable accepted without code");

  ref_stop_freeze_a: assert property (  // see RQ7
    @(posedge hclk) disable iff (!hresetn)
    !ref_tick && !restart |=> $stable(count))
    else $error("count moved without a reference tick");

  reset_pulse_a: assert property (  // see RQ3
    @(posedge hclk) disable iff (!hresetn)
    wdt_reset_req |=> !wdt_reset_req)
    else $error("reset request longer than one cycle");

  cause_sticky_a: assert property (  // see RQ16
    @(posedge hclk) disable iff (!hresetn)
    reset_cause_wdt_flag && !(wr_commit && st.ap_sel == SEL_CAUSE)
    |=> reset_cause_wdt_flag)
    else $error("cause flag dropped without a clear");

  warn_sticky_a: assert property (  // see RQ4
    @(posedge hclk) disable iff (!hresetn)
    early_warn_nmi && !(wr_commit && st.ap_sel == SEL_STAT)
    |=> early_warn_nmi)
    else $error("warning dropped without a clear");

endmodule
`default_nettype wire

// file: dv/tb_protected_watchdog_timer.sv
`timescale 1ns/100ps
`default_nettype none
module tb_protected_watchdog_timer
  import wdt_pkg::*;
;
  // ***********************************
  // short counts keep the run brief
  // ***********************************
  localparam int W = 6;  // early warning, in ticks
  localparam int E = 8;  // expiry, in ticks

  logic        hclk;                   // system clock
  logic        hresetn;                // always-on reset
  logic        hsel;                   // slave select
  logic [31:0] haddr;                  // byte address
  logic [1:0]  htrans;                 // transfer type
  logic        hwrite;                 // write strobe
  logic [2:0]  hsize;                  // always a word
  logic [3:0]  hprot;                  // bit 1 privileged
  logic [31:0] hwdata;                 // write data
  wire logic   hready;                 // looped from the slave
  logic        hreadyout;              // slave ready
  logic        hresp;                  // response
  logic [31:0] hrdata;                 // read data
  logic        millisecond_ref_clock;  // reference pin
  logic        cpu_debug_halted;       // debugger halt
  logic        wdt_reset_req;          // expiry pulse
  logic        early_warn_nmi;         // warning level
  logic        irq;                    // masked events
  logic        reset_cause_wdt_flag;   // expiry recorded
  logic        wdt_active;             // watchdog running
  logic [31:0] rd;                     // last read word
  int          err_count;              // mismatches
  int          n_compared;             // comparisons made
  int          n_rst = 0;              // expiry pulses seen

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  protected_watchdog_timer #(.WARN(W), .EXPIRE(E)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hprot(hprot),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata),
    .millisecond_ref_clock(millisecond_ref_clock),
    .cpu_debug_halted(cpu_debug_halted),
    .wdt_reset_req(wdt_reset_req), .early_warn_nmi(early_warn_nmi),
    .irq(irq), .reset_cause_wdt_flag(reset_cause_wdt_flag),
    .wdt_active(wdt_active)
  );

  // ***********************************
  // clock and pulse counter
  // ***********************************
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // the reset request lasts one cycle, so count it at every edge
  always @(posedge hclk) begin
    if (wdt_reset_req === 1'b1) begin
      n_rst <= n_rst + 1;
    end
  end

  // ***********************************
  // shared tasks
  // ***********************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // bounded wait for hready high at a rising edge
  task automatic wait_ready;
    int k;
    k = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      k++;
      if (k > 50) begin
        err_count++;
        test_done;
      end
      @(posedge hclk);
    end
  endtask

  // one single word transfer; read data taken at the closing edge
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d, input logic p);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hprot  <= {2'b00, p, 1'b1};
    wait_ready;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready;
    rd = hrdata;
  endtask

  // privileged write, then one edge so the new state has landed
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b1);
    @(posedge hclk);
  endtask

  task automatic get(input logic [31:0] a);
    bus(1'b0, a, 32'h0, 1'b1);
  endtask

  // n reference edges, spaced well beyond the synchroniser delay
  task automatic ticks(input int n);
    repeat (n) begin
      millisecond_ref_clock <= 1'b1;
      repeat (5) @(posedge hclk);
      millisecond_ref_clock <= 1'b0;
      repeat (5) @(posedge hclk);
    end
  endtask

  // ***********************************
  // scenarios
  // ***********************************
  task automatic t_reset;
    get(CONFIG_ADDR);
    check(rd, CFG_RESET);
    check(32'(wdt_active), 32'h0);
    get(UNLOCK_ADDR);
    check(rd, 32'h0);
    get(DBG_CFG_ADDR);
    check(rd, DBG_CFG_RESET);
    get(KICK_ADDR);
    check(rd, 32'h0);
    get(32'h4000_6040);
    check(rd, 32'h0);
    ticks(E + 1);
    check(32'(n_rst), 32'h0);
  endtask

  // bit writes without the matching code, and an unprivileged code write, do nothing
  task automatic t_lock;
    wr(CONFIG_ADDR, 32'h1);
    check(32'(wdt_active), 32'h0);
    wr(UNLOCK_ADDR, {16'h0, UNLOCK_OFF_CODE});
    wr(CONFIG_ADDR, 32'h1);
    check(32'(wdt_active), 32'h0);
    get(UNLOCK_ADDR);
    check(rd, {16'h0, UNLOCK_OFF_CODE});
    bus(1'b1, UNLOCK_ADDR, {16'h0, UNLOCK_ON_CODE}, 1'b0);
    check(32'(hresp), 32'h0);
    get(UNLOCK_ADDR);
    check(rd, {16'h0, UNLOCK_OFF_CODE});
    wr(UNLOCK_ADDR, {16'h0, UNLOCK_ON_CODE});
    wr(CONFIG_ADDR, 32'h1);
    check(32'(wdt_active), 32'h1);
    get(CONFIG_ADDR);
    check(rd, 32'h1);
    get(UNLOCK_ADDR);
    check(rd, 32'h0);
  endtask

  // no warning one tick early, warning at tick W, expiry, then event bits and interrupt
  task automatic t_count;
    ticks(W - 1);
    check(32'(early_warn_nmi), 32'h0);
    ticks(1);
    check(32'(early_warn_nmi), 32'h1);
    check(32'(irq), 32'h0);
    ticks(E - W - 1);
    check(32'(n_rst), 32'h0);
    ticks(1);
    check(32'(n_rst), 32'h1);
    check(32'(reset_cause_wdt_flag), 32'h1);
    get(CAUSE_ADDR);
    check(rd, 32'h8);
    get(IRQ_STAT_ADDR);
    check(rd, 32'h3);
    wr(IRQ_MASK_ADDR, 32'h2);
    check(32'(irq), 32'h1);
    wr(IRQ_STAT_ADDR, 32'h3);
    check(32'(irq), 32'h0);
    check(32'(early_warn_nmi), 32'h0);
    wr(CAUSE_ADDR, 32'h8);
    check(32'(reset_cause_wdt_flag), 32'h0);
  endtask

  // a kick one tick before expiry restarts the full interval
  task automatic t_kick;
    ticks(E - 1);
    wr(KICK_ADDR, 32'h1234_5678);
    ticks(E - 1);
    check(32'(n_rst), 32'h1);
    ticks(1);
    check(32'(n_rst), 32'h2);
  endtask

  // debug hold, a stopped reference, and the hold option cleared
  task automatic t_hold;
    cpu_debug_halted <= 1'b1;
    ticks(E);
    check(32'(n_rst), 32'h2);
    cpu_debug_halted <= 1'b0;
    ticks(E - 1);
    repeat (300) @(posedge hclk);
    check(32'(n_rst), 32'h2);
    ticks(1);
    check(32'(n_rst), 32'h3);
    wr(DBG_CFG_ADDR, 32'h0);
    get(DBG_CFG_ADDR);
    check(rd, 32'h0);
    cpu_debug_halted <= 1'b1;
    ticks(E);
    check(32'(n_rst), 32'h4);
    cpu_debug_halted <= 1'b0;
  endtask

  // disable refused without its code, then done properly
  task automatic t_off;
    wr(CONFIG_ADDR, 32'h2);
    check(32'(wdt_active), 32'h1);
    wr(UNLOCK_ADDR, {16'h0, UNLOCK_OFF_CODE});
    wr(CONFIG_ADDR, 32'h2);
    check(32'(wdt_active), 32'h0);
    get(CONFIG_ADDR);
    check(rd, 32'h2);
    ticks(E);
    check(32'(n_rst), 32'h4);
  endtask

  // ***********************************
  // main sequence
  // ***********************************
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hprot = 4'h3;
    hwdata = 32'h0;
    millisecond_ref_clock = 1'b0;
    cpu_debug_halted = 1'b0;
    err_count = 0;
    n_compared = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    // first address phase only after the first edge out of reset
    @(posedge hclk);
    t_reset;
    t_lock;
    t_count;
    t_kick;
    t_hold;
    t_off;
    test_done;
  end
endmodule
`default_nettype wire
